// ==== lrcc_map.svh ====
// register offsets, reset values and field positions of the line
// interface configuration block; definitions only
`ifndef LRCC_MAP_SVH
`define LRCC_MAP_SVH

// ************************************************************
// byte offsets on the apb bus; the channel base is the value of paddr[7:6]
// ************************************************************
`define LRCC_GCTRL_OFS 8'h00
`define LRCC_THRESH_OFS 8'h04
`define LRCC_STAT_OFS 8'h08
`define LRCC_MASK_OFS 8'h0C
`define LRCC_STATE_OFS 8'h10
`define LRCC_CHAN_BASE 2'h1

// ************************************************************
// reset values
// ************************************************************
`define LRCC_GCTRL_RST 10'h000
`define LRCC_CHAN_RST 7'h00
`define LRCC_THRESH_RST 6'h3F

// ************************************************************
// field positions
// ************************************************************
`define LRCC_CL_LSB 8
`define LRCC_CL_W 6

`endif

// ==== lrcc_pkg.sv ====
// types shared by the line interface configuration block
// assumes lrcc_map.svh is compiled alongside
package lrcc_pkg;

    // global control word
    typedef struct packed {
        logic irqGate;
        logic [1:0] decisionLevelPick;
        logic termPinOverrideEn;
        logic stdE1;
        logic singleStandardGateOff;
        logic [3:0] refFreqPick;
    } lrcc_gctrl_s;

    // per-channel control word
    typedef struct packed {
        logic alarmEn;
        logic rateE1;
        logic [1:0] extResistorPick;
        logic rxInternalTermOn;
        logic [1:0] impedancePick;
    } lrcc_chan_s;

    typedef logic [5:0] lrcc_loss_t;

endpackage : lrcc_pkg

// ==== lrcc_top.sv ====
// configuration, clock-select and cable-loss alarm logic of a
// multi-channel t1/e1 line interface, reached over apb
// assumes: one 100 MHz clock, analog cable-loss readings and the
// termination pin arrive asynchronously
`timescale 1ns/1ns
`include "lrcc_map.svh"

module lrcc_top #(
    parameter int NCH = 14
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic termPinIn,
    input wire logic [NCH-1:0][5:0] cableLossIn,
    output logic [3:0] refFreqPick,
    output logic [14:0] refFreqKhz,
    output logic t1RefRun,
    output logic e1RefRun,
    output logic ref8kRun,
    output logic [1:0] decisionLevelPick,
    output logic [NCH-1:0][1:0] impedancePick,
    output logic [NCH-1:0] rxInternalTermOn,
    output logic [NCH-1:0][1:0] extResistorPick,
    output logic [NCH-1:0] chanRateClkOn,
    output logic irq,
    output logic irqN
);

    // ************************************************************
    // reference frequency decode
    // ************************************************************
    function automatic logic [14:0] lrcc_khz(input logic [3:0] c);
        case (c)
            4'h0: lrcc_khz = 15'h0800;
            4'h1: lrcc_khz = 15'h0608;
            4'h2: lrcc_khz = 15'h0008;
            4'h3: lrcc_khz = 15'h0010;
            4'h4: lrcc_khz = 15'h0038;
            4'h5: lrcc_khz = 15'h0040;
            4'h6: lrcc_khz = 15'h0080;
            4'h7: lrcc_khz = 15'h0100;
            4'h8: lrcc_khz = 15'h1000;
            4'h9: lrcc_khz = 15'h0C10;
            4'hA: lrcc_khz = 15'h2000;
            4'hB: lrcc_khz = 15'h1820;
            4'hC: lrcc_khz = 15'h4000;
            4'hD: lrcc_khz = 15'h3040;
            4'hE: lrcc_khz = 15'h0800;
            default: lrcc_khz = 15'h0608;
        endcase
    endfunction : lrcc_khz

    // ************************************************************
    // register state
    // ************************************************************
    lrcc_pkg::lrcc_gctrl_s gctrl_r;
    lrcc_pkg::lrcc_chan_s [NCH-1:0] chan_r;
    lrcc_pkg::lrcc_loss_t thresh_r;
    logic [NCH-1:0] stat_r;
    logic [NCH-1:0] mask_r;
    logic [NCH-1:0] stat_nxt;
    logic [1:0] pinSync_r;
    logic [NCH-1:0][5:0] clS1_r;
    logic [NCH-1:0][5:0] clS2_r;
    logic [NCH-1:0][5:0] clS3_r;
    logic [NCH-1:0][5:0] loss_r;
    logic [NCH-1:0] cond_r;
    logic [NCH-1:0] cond_nxt;

    // ************************************************************
    // apb decode
    // ************************************************************
    // one wait state: pready rises in the second access cycle so that
    // read data can come straight from a flop
    wire access = psel && penable;
    wire fire = access && pready;
    wire wrFire = fire && pwrite;
    wire rdFire = fire && !pwrite;
    wire aligned = paddr[1:0] == 2'h0;
    wire [3:0] chIdx = paddr[5:2];
    wire chHit = paddr[7:6] == `LRCC_CHAN_BASE && aligned && chIdx < NCH;
    wire hitG = paddr == `LRCC_GCTRL_OFS;
    wire hitT = paddr == `LRCC_THRESH_OFS;
    wire hitS = paddr == `LRCC_STAT_OFS;
    wire hitM = paddr == `LRCC_MASK_OFS;
    wire hitX = paddr == `LRCC_STATE_OFS;
    wire mapped = hitG || hitT || hitS || hitM || hitX || chHit;
    wire [31:0] chWord = chHit ?
        {18'h0, loss_r[chIdx], 1'b0, chan_r[chIdx]} : 32'h0;
    wire [31:0] rdMux =
        hitG ? {22'h0, gctrl_r} :
        hitT ? {26'h0, thresh_r} :
        hitS ? {{(32-NCH){1'b0}}, stat_r} :
        hitM ? {{(32-NCH){1'b0}}, mask_r} :
        hitX ? {28'h0, pinSync_r[1], ref8kRun, e1RefRun, t1RefRun} :
        chWord;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access && !pready;
            prdata <= (access && !pready && !pwrite) ? rdMux : 32'h0;
            pslverr <= access && !pready && !mapped;
        end
    end

    // ************************************************************
    // global registers
    // ************************************************************
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            gctrl_r <= `LRCC_GCTRL_RST;
            thresh_r <= `LRCC_THRESH_RST;
            mask_r <= '0;
        end
        else if (wrFire)
        begin
            if (hitG)
                gctrl_r <= pwdata[9:0];
            if (hitT)
                thresh_r <= pwdata[5:0];
            if (hitM)
                mask_r <= pwdata[NCH-1:0];
        end
    end

    // ************************************************************
    // per-channel registers and loss capture
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : gChan
            wire wrCh = wrFire && chHit && chIdx == g;
            always_ff @(posedge ref_clk)
            begin
                if (!rstn)
                    chan_r[g] <= `LRCC_CHAN_RST;
                else if (wrCh)
                    chan_r[g] <= pwdata[6:0];
            end
            assign cond_nxt[g] = thresh_r <= loss_r[g];
        end
    endgenerate

    // the reading is multi-bit and asynchronous: accept it only when
    // two later stages agree, so a skewed sample is never compared
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            clS1_r <= '0;
            clS2_r <= '0;
            clS3_r <= '0;
            loss_r <= '0;
            pinSync_r <= 2'h0;
        end
        else
        begin
            clS1_r <= cableLossIn;
            clS2_r <= clS1_r;
            clS3_r <= clS2_r;
            for (int i = 0; i < NCH; i++)
                if (clS2_r[i] == clS3_r[i])
                    loss_r[i] <= clS3_r[i];
            pinSync_r <= {pinSync_r[0], termPinIn};
        end
    end

    // ************************************************************
    // alarm status and interrupt
    // ************************************************************
    // a change of the comparison sets the sticky bit; set wins over
    // a clear by read or by write-one in the same cycle
    wire [NCH-1:0] chEn;
    wire [NCH-1:0] evt = (cond_nxt ^ cond_r) & chEn &
        {NCH{gctrl_r.irqGate}};
    wire [NCH-1:0] clrW = (wrFire && hitS) ? pwdata[NCH-1:0] : '0;
    // clear only what the read returned: an event that lands during
    // the access stays pending for the next read
    wire [NCH-1:0] clrR = (rdFire && hitS) ? prdata[NCH-1:0] : '0;
    assign stat_nxt = evt | (stat_r & ~(clrW | clrR));
    wire irqNxt = |(stat_nxt & mask_r);

    generate
        for (g = 0; g < NCH; g++)
        begin : gEn
            assign chEn[g] = chan_r[g].alarmEn;
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            stat_r <= '0;
            cond_r <= '0;
            irq <= 1'b0;
            irqN <= 1'b1;
        end
        else
        begin
            stat_r <= stat_nxt;
            cond_r <= cond_nxt;
            irq <= irqNxt;
            irqN <= !irqNxt;
        end
    end

    // ************************************************************
    // clock references and line-side controls
    // ************************************************************
    wire gOff = gctrl_r.singleStandardGateOff;
    wire t1Nxt = gOff || !gctrl_r.stdE1;
    wire e1Nxt = gOff || gctrl_r.stdE1;
    wire ovr = gctrl_r.termPinOverrideEn;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            refFreqKhz <= 15'h0800;
            t1RefRun <= 1'b0;
            e1RefRun <= 1'b0;
            ref8kRun <= 1'b0;
            rxInternalTermOn <= '0;
            chanRateClkOn <= '0;
        end
        else
        begin
            refFreqKhz <= lrcc_khz(gctrl_r.refFreqPick);
            t1RefRun <= t1Nxt;
            e1RefRun <= e1Nxt;
            ref8kRun <= e1Nxt;
            for (int i = 0; i < NCH; i++)
            begin
                rxInternalTermOn[i] <= ovr ? pinSync_r[1] :
                    chan_r[i].rxInternalTermOn;
                chanRateClkOn[i] <= chan_r[i].rateE1 ?
                    e1Nxt : t1Nxt;
            end
        end
    end

    assign refFreqPick = gctrl_r.refFreqPick;
    assign decisionLevelPick = gctrl_r.decisionLevelPick;

    generate
        for (g = 0; g < NCH; g++)
        begin : gOut
            assign impedancePick[g] = chan_r[g].impedancePick;
            assign extResistorPick[g] = chan_r[g].extResistorPick;
        end
    endgenerate

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_statRead;
        psel && penable && pready && !pwrite && paddr == `LRCC_STAT_OFS;
    endsequence

    sequence s_gateT1;
        !gctrl_r.singleStandardGateOff && !gctrl_r.stdE1;
    endsequence

    property p_resetGate;
        @(posedge ref_clk) !rstn |=> !gctrl_r.singleStandardGateOff;
    endproperty
    a_resetGate: assert property (p_resetGate)
        else $error("gating not active after reset");

    property p_gateT1;
        @(posedge ref_clk) disable iff (!rstn)
        s_gateT1 |=> t1RefRun && !e1RefRun && !ref8kRun;
    endproperty
    a_gateT1: assert property (p_gateT1)
        else $error("e1 or 8k reference running in t1 gating");

    property p_gateE1;
        @(posedge ref_clk) disable iff (!rstn)
        !gctrl_r.singleStandardGateOff && gctrl_r.stdE1
        |=> !t1RefRun && e1RefRun && ref8kRun;
    endproperty
    a_gateE1: assert property (p_gateE1)
        else $error("wrong references in e1 gating");

    property p_gateOff;
        @(posedge ref_clk) disable iff (!rstn)
        gctrl_r.singleStandardGateOff
        |=> t1RefRun && e1RefRun && ref8kRun;
    endproperty
    a_gateOff: assert property (p_gateOff)
        else $error("reference stopped with gating off");

    property p_khz8;
        @(posedge ref_clk) disable iff (!rstn)
        gctrl_r.refFreqPick == 4'h2 |=> refFreqKhz == 15'h0008;
    endproperty
    a_khz8: assert property (p_khz8)
        else $error("code 2 does not select 8 kHz");

    property p_termPin;
        @(posedge ref_clk) disable iff (!rstn)
        ovr |=> rxInternalTermOn[0] == $past(pinSync_r[1]);
    endproperty
    a_termPin: assert property (p_termPin)
        else $error("override pin not applied");

    property p_termBit;
        @(posedge ref_clk) disable iff (!rstn)
        !ovr |=> rxInternalTermOn[2] == $past(chan_r[2].rxInternalTermOn);
    endproperty
    a_termBit: assert property (p_termBit)
        else $error("termination bit not applied");

    property p_alarmSet;
        @(posedge ref_clk) disable iff (!rstn)
        (cond_nxt[3] != cond_r[3]) && chan_r[3].alarmEn &&
        gctrl_r.irqGate |=> stat_r[3];
    endproperty
    a_alarmSet: assert property (p_alarmSet)
        else $error("alarm change not latched");

    property p_readClr;
        @(posedge ref_clk) disable iff (!rstn)
        s_statRead ##0 (evt == '0) |=>
            (stat_r & $past(prdata[NCH-1:0])) == '0 &&
            (stat_r != '0 || (!irq && irqN));
    endproperty
    a_readClr: assert property (p_readClr)
        else $error("status read did not clear");

    property p_irqLow;
        @(posedge ref_clk) disable iff (!rstn)
        (stat_r & mask_r) != '0 && mask_r == $past(mask_r)
        |-> !irqN && irq;
    endproperty
    a_irqLow: assert property (p_irqLow)
        else $error("interrupt not driven low");

endmodule : lrcc_top

// ==== lrcc_line_model.sv ====
// line side stand-in: delivers cable-loss readings and the override pin
// assumes the bench asks for values on ref_clk; lines settle off the edge
`timescale 1ns/1ns

module lrcc_line_model #(
    parameter int NCH = 14
) (
    input wire logic ref_clk,
    input wire logic [NCH-1:0][5:0] lossReq,
    input wire logic pinReq,
    output logic [NCH-1:0][5:0] cableLossIn,
    output logic termPinIn
);
    // analog readings are asynchronous, so they move mid-cycle
    initial
    begin
        cableLossIn = '0;
        termPinIn = 1'b0;
    end

    always @(posedge ref_clk)
    begin
        #3;
        cableLossIn = lossReq;
        termPinIn = pinReq;
    end
endmodule : lrcc_line_model

// ==== liu_rx_config_clock_select_tb.sv ====
// self-checking bench of lrcc_top over apb with a line side model
// assumes lrcc_map.svh and lrcc_pkg are compiled first
`timescale 1ns/1ns
`include "lrcc_map.svh"

module liu_rx_config_clock_select_tb;
    logic ref_clk = 1'b0, rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, termPinIn, pinReq = 1'b0, t1RefRun, e1RefRun;
    logic ref8kRun, irq, irqN;
    logic [13:0][5:0] cableLossIn, lossReq = '0;
    logic [3:0] refFreqPick;
    logic [14:0] refFreqKhz;
    logic [1:0] decisionLevelPick;
    logic [13:0][1:0] impedancePick, extResistorPick;
    logic [13:0] rxInternalTermOn, chanRateClkOn, termPat, ratePat;
    logic [14:0] khz [16] = '{15'h0800, 15'h0608, 15'h0008, 15'h0010,
        15'h0038, 15'h0040, 15'h0080, 15'h0100, 15'h1000, 15'h0C10,
        15'h2000, 15'h1820, 15'h4000, 15'h3040, 15'h0800, 15'h0608};
    logic [6:0] v;
    int errCount = 0, totalChecks = 0;

    always #5 ref_clk = ~ref_clk;

    lrcc_top #(.NCH(14)) u_lrcc_top (.ref_clk(ref_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .termPinIn(termPinIn),
        .cableLossIn(cableLossIn), .refFreqPick(refFreqPick),
        .refFreqKhz(refFreqKhz), .t1RefRun(t1RefRun), .e1RefRun(e1RefRun),
        .ref8kRun(ref8kRun), .decisionLevelPick(decisionLevelPick),
        .impedancePick(impedancePick), .rxInternalTermOn(rxInternalTermOn),
        .extResistorPick(extResistorPick), .chanRateClkOn(chanRateClkOn),
        .irq(irq), .irqN(irqN));

    lrcc_line_model #(.NCH(14)) u_lrcc_line_model (.ref_clk(ref_clk),
        .lossReq(lossReq), .pinReq(pinReq), .cableLossIn(cableLossIn),
        .termPinIn(termPinIn));

    // ************************************************************
    // access and compare tasks
    // ************************************************************
    task test_done;
        if (errCount == 0 && totalChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task chk(input string name, input logic [31:0] exp, got);
        totalChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // waits on pready only; the bench watchdog bounds a hang
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(name, exp, q);
    endtask : rd

    task settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : settle

    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        logic [31:0] q;
        logic e;
        settle(20);
        rstn <= 1'b1;
        settle(2);
        rd("gctrl", `LRCC_GCTRL_OFS, 32'h0);
        rd("thresh", `LRCC_THRESH_OFS, 32'h3F);
        rd("chan13", 8'h74, 32'h0);
        chk("termOn", 32'h0, 32'(rxInternalTermOn));
        chk("runs", 32'h1, 32'({ref8kRun, e1RefRun, t1RefRun}));
        chk("irqN", 32'h1, 32'(irqN));
        for (int i = 0; i < 16; i++)
        begin
            wr(`LRCC_GCTRL_OFS, 32'(i));
            settle(2);
            chk("refKhz", 32'(khz[i]), 32'(refFreqKhz));
            chk("refPick", 32'(i), 32'(refFreqPick));
        end
        wr(`LRCC_GCTRL_OFS, 32'h20);
        settle(2);
        chk("runsE1", 32'h6, 32'({ref8kRun, e1RefRun, t1RefRun}));
        chk("rateClkE1", 32'h0, 32'(chanRateClkOn));
        wr(`LRCC_GCTRL_OFS, 32'h10);
        settle(2);
        chk("runsAll", 32'h7, 32'({ref8kRun, e1RefRun, t1RefRun}));
        chk("rateClkAll", 32'h3FFF, 32'(chanRateClkOn));
        rd("state", `LRCC_STATE_OFS, 32'h7);
        for (int i = 0; i < 4; i++)
        begin
            wr(`LRCC_GCTRL_OFS, 32'(i) << 7);
            settle(2);
            chk("level", 32'(i), 32'(decisionLevelPick));
        end
        for (int c = 0; c < 14; c++)
            wr(8'(8'h40 + c * 4), 32'(7'(c * 11) & 7'h3F));
        for (int c = 0; c < 14; c++)
        begin
            v = 7'(c * 11) & 7'h3F;
            termPat[c] = v[2];
            ratePat[c] = v[5];
            rd("chan", 8'(8'h40 + c * 4), 32'(v));
            chk("imp", 32'(v[1:0]), 32'(impedancePick[c]));
            chk("res", 32'(v[4:3]), 32'(extResistorPick[c]));
        end
        chk("termOn", 32'(termPat), 32'(rxInternalTermOn));
        chk("rateClk", 32'(ratePat ^ 14'h3FFF), 32'(chanRateClkOn));
        wr(`LRCC_GCTRL_OFS, 32'h40);
        pinReq <= 1'b1;
        settle(8);
        chk("pinOn", 32'h3FFF, 32'(rxInternalTermOn));
        pinReq <= 1'b0;
        settle(8);
        chk("pinOff", 32'h0, 32'(rxInternalTermOn));
        wr(`LRCC_GCTRL_OFS, 32'h200);
        pinReq <= 1'b1;
        settle(8);
        chk("pinIgn", 32'(termPat), 32'(rxInternalTermOn));
        apb(1'b0, 8'h24, 32'h0, q, e);
        chk("slverr", 32'h1, 32'(e));
        wr(`LRCC_THRESH_OFS, 32'h10);
        wr(`LRCC_MASK_OFS, 32'h3FFF);
        wr(8'h4C, 32'h40);
        wr(8'h50, 32'h00);
        rd("statIdle", `LRCC_STAT_OFS, 32'h0);
        lossReq[3] <= 6'h10;
        lossReq[4] <= 6'h20;
        settle(10);
        rd("loss", 8'h4C, 32'h1040);
        chk("irqN", 32'h0, 32'(irqN));
        rd("stat", `LRCC_STAT_OFS, 32'h8);
        settle(2);
        chk("irqClr", 32'h2, 32'({irqN, irq}));
        rd("statRc", `LRCC_STAT_OFS, 32'h0);
        wr(`LRCC_MASK_OFS, 32'h0);
        lossReq[3] <= 6'h0F;
        settle(10);
        chk("irqMask", 32'h0, 32'(irq));
        wr(`LRCC_MASK_OFS, 32'h3FFF);
        settle(2);
        chk("irqFall", 32'h1, 32'(irq));
        wr(`LRCC_STAT_OFS, 32'h8);
        settle(2);
        chk("irqW1c", 32'h0, 32'(irq));
        rd("statW1c", `LRCC_STAT_OFS, 32'h0);
        wr(`LRCC_GCTRL_OFS, 32'h0);
        lossReq[3] <= 6'h30;
        settle(10);
        rd("statGate", `LRCC_STAT_OFS, 32'h0);
        test_done;
    end

    initial
    begin
        settle(20000);
        errCount++;
        test_done;
    end
endmodule : liu_rx_config_clock_select_tb
